// ### pkg/mdmac_pkg.sv
// Constants, field layout and types of the multiply/divide/accumulate unit
//
// Function
// - Unsigned accumulate sets overflow on carry out
// - Signed accumulate overflows when like signs flip
// - Sign flag mirrors bit 31, zero unsigned
// - Overflow and sign flags ignore control register writes
// - Start bit accepted only in division mode
// - Start bit reads one, cleared at end
// - Writing zero to busy start bit ignored
// - Multiply starts once both A halves written
// - Product lands in operand B next clock
// - Accumulate triggered by write of A high
// - Product after one clock, accumulator after two
// - Accumulate overflow sets flag and raises request
// - Signed: negative C high write sets sign
// - Division completes sixteen clocks after start
// - Division end requests only with accumulate-select zero
// - Quotient to operand A, remainder to accumulator
// - Mode bits decode multiply, accumulate, divide
// - Accumulator plus A low times A high
// - Control register clears to zero on reset
package mdmac_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_A_HIGH = 8'h04;
    localparam logic [7:0] OFF_A_LOW  = 8'h08;
    localparam logic [7:0] OFF_B_HIGH = 8'h0C;
    localparam logic [7:0] OFF_B_LOW  = 8'h10;
    localparam logic [7:0] OFF_C_HIGH = 8'h14;
    localparam logic [7:0] OFF_C_LOW  = 8'h18;

    // ----------------------------------------
    // Control register fields and reset values
    // ----------------------------------------
    localparam int CTRL_DIVIDE_SELECT     = 7;
    localparam int CTRL_ACCUMULATE_SELECT = 6;
    localparam int CTRL_SIGNED_SELECT     = 3;
    localparam int CTRL_OVERFLOW_FLAG     = 2;
    localparam int CTRL_SIGN_FLAG         = 1;
    localparam int CTRL_DIVIDE_START      = 0;
    localparam logic [7:0]  CTRL_RESET = 8'h00;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [31:0] READ_NONE  = 32'h0000_0000;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int MUL_CLOCKS     = 1;
    localparam int DIV_CLOCKS     = 16;
    localparam int DIV_STEPS      = 32 / DIV_CLOCKS;
    localparam logic [3:0] DIV_LAST = 4'(DIV_CLOCKS - 1);

    // Operation sequence, Gray coded along idle -> product -> accumulate
    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_PROD  = 2'b01,
        SEQ_ACCUM = 2'b11
    } mdmac_seq_t;

endpackage

// ### pkg/mdmac_div_if.sv
// Connection between the register block and the iterative divider
`timescale 1ns/1ps
interface mdmac_div_if;
    logic        start;
    logic [31:0] dividend;
    logic [31:0] divisor;
    logic        done;
    logic [31:0] quotient;
    logic [31:0] remainder;

    modport ctl  (output start, output dividend, output divisor,
                  input done, input quotient, input remainder);
    modport unit (input start, input dividend, input divisor,
                  output done, output quotient, output remainder);
endinterface

// ### verilog/mdmac_divider.sv
// Unsigned 32/32 radix-2 divider, two quotient bits per clock
`timescale 1ns/1ps
module mdmac_divider (
    input  wire logic     clk_i,
    input  wire logic     rst_i,
    input  wire logic     ce_i,
    mdmac_div_if.unit     div_io
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic        busy;
        logic        done;
        logic [3:0]  cnt;
        logic [31:0] quo;
        logic [31:0] rem;
        logic [31:0] dsr;
    } mdmac_div_state_t;

    mdmac_div_state_t r;
    mdmac_div_state_t next_r;

    // ----------------------------------------
    // Iteration
    // ----------------------------------------
    always_comb begin
        logic [32:0] trial;
        logic [31:0] quo;
        logic [31:0] rem;
        logic [31:0] dsr;
        logic        go;
        trial  = 33'h0_0000_0000;
        next_r = r;
        next_r.done = 1'b0;
        quo = r.quo;
        rem = r.rem;
        dsr = r.dsr;
        go  = 1'b0;
        // First bits are resolved on the start edge itself so the 16th clock finishes
        if (div_io.start) begin
            quo = div_io.dividend;
            rem = 32'h0000_0000;
            dsr = div_io.divisor;
            next_r.cnt  = 4'h1;
            next_r.busy = 1'b1;
            go = 1'b1;
        end else if (r.busy) begin
            go = 1'b1;
            next_r.cnt = r.cnt + 4'h1;
            if (r.cnt == mdmac_pkg::DIV_LAST) begin
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
            end
        end
        if (go) begin
            for (int i = 0; i < mdmac_pkg::DIV_STEPS; i++) begin
                trial = {rem, quo[31]};
                quo   = {quo[30:0], 1'b0};
                // Zero divisor is undefined; it simply yields all-ones quotient
                if (trial >= {1'b0, dsr}) begin
                    trial  = trial - {1'b0, dsr};
                    quo[0] = 1'b1;
                end
                rem = trial[31:0];
            end
        end
        next_r.quo = quo;
        next_r.rem = rem;
        next_r.dsr = dsr;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    assign div_io.done      = r.done;
    assign div_io.quotient  = r.quo;
    assign div_io.remainder = r.rem;

endmodule

// ### verilog/mdmac_unit.sv
// Memory-mapped multiply, multiply-accumulate and divide unit on classic Wishbone
`timescale 1ns/1ps
module mdmac_unit (
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_I,
    input  wire logic        CE_I,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output wire logic [31:0] DAT_O,
    output wire logic        ACK_O,
    output wire logic        ARITH_DONE_IRQ_O
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic                   ack;
        logic [31:0]            rdata;
        logic                   irq;
        logic                   divide_select;
        logic                   accumulate_select;
        logic                   signed_select;
        logic                   overflow_flag;
        logic                   sign_flag;
        logic                   divide_start;
        logic [15:0]            a_high;
        logic [15:0]            a_low;
        logic [15:0]            b_high;
        logic [15:0]            b_low;
        logic [15:0]            c_high;
        logic [15:0]            c_low;
        logic                   high_seen;
        logic                   low_seen;
        mdmac_pkg::mdmac_seq_t  seq;
    } mdmac_state_t;

    mdmac_state_t r;
    mdmac_state_t next_r;

    mdmac_div_if div_link ();

    // ----------------------------------------
    // Arithmetic
    // ----------------------------------------
    logic               mode_mul;
    logic               mode_mac;
    logic               mode_smac;
    logic signed [31:0] prod_signed;
    logic [31:0]        prod_unsigned;
    logic [31:0]        product;
    logic [31:0]        accum;
    logic [31:0]        addend;
    logic [32:0]        sum;
    logic               ovf_unsigned;
    logic               ovf_signed;
    logic [7:0]         ctrl_read;

    // Prohibited codes behave as the nearest legal mode: divide bit dominates
    assign mode_mul  = ~r.divide_select & ~r.accumulate_select;
    assign mode_mac  = ~r.divide_select & r.accumulate_select;
    assign mode_smac = mode_mac & r.signed_select;

    assign prod_signed   = $signed(r.a_low) * $signed(r.a_high);
    assign prod_unsigned = {16'h0000, r.a_low} * {16'h0000, r.a_high};
    assign product       = r.signed_select ? prod_signed : prod_unsigned;

    // Accumulate adds the product already latched into operand B
    assign accum  = {r.c_high, r.c_low};
    assign addend = {r.b_high, r.b_low};
    assign sum    = {1'b0, accum} + {1'b0, addend};

    assign ovf_unsigned = sum[32];
    assign ovf_signed   = (accum[31] == addend[31]) & (sum[31] != accum[31]);

    // Sign flag is masked outside signed accumulate so it never shows stale state
    assign ctrl_read = {r.divide_select, r.accumulate_select, 2'b00, r.signed_select,
                        r.overflow_flag, r.sign_flag & mode_smac, r.divide_start};

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic bus_req;
    logic bus_wr;
    logic wr_ctrl;
    logic wr_a_high;
    logic wr_a_low;
    logic wr_b_high;
    logic wr_b_low;
    logic wr_c_high;
    logic wr_c_low;
    logic div_go;

    assign bus_req   = CYC_I & STB_I;
    assign bus_wr    = bus_req & r.ack & WE_I;
    assign wr_ctrl   = bus_wr & SEL_I[0] & (ADR_I == mdmac_pkg::OFF_CTRL);
    assign wr_a_high = bus_wr & (|SEL_I[1:0]) & (ADR_I == mdmac_pkg::OFF_A_HIGH);
    assign wr_a_low  = bus_wr & (|SEL_I[1:0]) & (ADR_I == mdmac_pkg::OFF_A_LOW);
    assign wr_b_high = bus_wr & (|SEL_I[1:0]) & (ADR_I == mdmac_pkg::OFF_B_HIGH);
    assign wr_b_low  = bus_wr & (|SEL_I[1:0]) & (ADR_I == mdmac_pkg::OFF_B_LOW);
    assign wr_c_high = bus_wr & (|SEL_I[1:0]) & (ADR_I == mdmac_pkg::OFF_C_HIGH);
    assign wr_c_low  = bus_wr & (|SEL_I[1:0]) & (ADR_I == mdmac_pkg::OFF_C_LOW);

    // A one starts only with division mode written and no division running
    assign div_go = wr_ctrl & DAT_I[mdmac_pkg::CTRL_DIVIDE_START]
                  & DAT_I[mdmac_pkg::CTRL_DIVIDE_SELECT] & ~r.divide_start;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
        merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
    endfunction

    function automatic logic [31:0] read_mux(input mdmac_state_t s,
                                             input logic [7:0]   adr,
                                             input logic [7:0]   ctrl);
        unique case (adr)
            mdmac_pkg::OFF_CTRL:   read_mux = {24'h00_0000, ctrl};
            mdmac_pkg::OFF_A_HIGH: read_mux = {16'h0000, s.a_high};
            mdmac_pkg::OFF_A_LOW:  read_mux = {16'h0000, s.a_low};
            mdmac_pkg::OFF_B_HIGH: read_mux = {16'h0000, s.b_high};
            mdmac_pkg::OFF_B_LOW:  read_mux = {16'h0000, s.b_low};
            mdmac_pkg::OFF_C_HIGH: read_mux = {16'h0000, s.c_high};
            mdmac_pkg::OFF_C_LOW:  read_mux = {16'h0000, s.c_low};
            default:               read_mux = mdmac_pkg::READ_NONE;
        endcase
    endfunction

    // ----------------------------------------
    // Divider
    // ----------------------------------------
    assign div_link.start    = div_go;
    assign div_link.dividend = {r.a_high, r.a_low};
    assign div_link.divisor  = {r.b_high, r.b_low};

    mdmac_divider u_divider (
        .clk_i  (REF_CLK_I),
        .rst_i  (RST_I),
        .ce_i   (CE_I),
        .div_io (div_link)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_r = r;
        next_r.irq = 1'b0;

        // Single-cycle classic slave: ack one clock after request, writes on the ack edge
        // Read data reloads on reads only, so it holds from one read to the next
        next_r.ack = bus_req & ~r.ack;
        if (bus_req & ~r.ack & ~WE_I) begin
            next_r.rdata = read_mux(r, ADR_I, ctrl_read);
        end

        // Control register; flag positions are never taken from the bus
        if (wr_ctrl) begin
            // Mode is frozen while dividing so a stray write cannot corrupt the result
            if (!r.divide_start) begin
                next_r.divide_select     = DAT_I[mdmac_pkg::CTRL_DIVIDE_SELECT];
                next_r.accumulate_select = DAT_I[mdmac_pkg::CTRL_ACCUMULATE_SELECT];
                next_r.signed_select     = DAT_I[mdmac_pkg::CTRL_SIGNED_SELECT];
            end
            // After a control write, multiply mode needs both A halves again before it multiplies; accumulate needs only A high
            next_r.high_seen = 1'b0;
            next_r.low_seen  = 1'b0;
        end
        if (div_go) begin
            next_r.divide_start = 1'b1;
        end
        // A zero written while busy leaves divide_start untouched

        // Operand and data registers
        if (wr_a_low) begin
            next_r.a_low = merge16(r.a_low, DAT_I, SEL_I);
            next_r.low_seen = 1'b1;
            if (mode_mul && r.high_seen) begin
                next_r.high_seen = 1'b0;
                next_r.seq = mdmac_pkg::SEQ_PROD;
            end
        end
        if (wr_a_high) begin
            next_r.a_high = merge16(r.a_high, DAT_I, SEL_I);
            if (mode_mul) begin
                // Multiplicand stays valid, so a lone multiplier write repeats the multiply
                if (r.low_seen || wr_a_low) begin
                    next_r.high_seen = 1'b0;
                    next_r.seq = mdmac_pkg::SEQ_PROD;
                end else begin
                    next_r.high_seen = 1'b1;
                end
            end
            if (mode_mac) begin
                next_r.seq = mdmac_pkg::SEQ_PROD;
            end
        end
        if (wr_b_high) begin
            next_r.b_high = merge16(r.b_high, DAT_I, SEL_I);
        end
        if (wr_b_low) begin
            next_r.b_low = merge16(r.b_low, DAT_I, SEL_I);
        end
        if (wr_c_high) begin
            next_r.c_high = merge16(r.c_high, DAT_I, SEL_I);
            if (mode_smac && SEL_I[1]) begin
                next_r.sign_flag = DAT_I[15];
            end
        end
        if (wr_c_low) begin
            next_r.c_low = merge16(r.c_low, DAT_I, SEL_I);
        end

        // Multiply and accumulate sequence; results override same-cycle bus writes
        unique case (r.seq)
            mdmac_pkg::SEQ_IDLE: begin
            end
            mdmac_pkg::SEQ_PROD: begin
                next_r.b_high = product[31:16];
                next_r.b_low  = product[15:0];
                next_r.seq = mode_mac ? mdmac_pkg::SEQ_ACCUM : mdmac_pkg::SEQ_IDLE;
                // An A high trigger arriving during this cycle restarts the sequence; an A low trigger is lost
                if (wr_a_high && (mode_mac || r.low_seen)) begin
                    next_r.seq = mdmac_pkg::SEQ_PROD;
                end
            end
            mdmac_pkg::SEQ_ACCUM: begin
                next_r.c_high = sum[31:16];
                next_r.c_low  = sum[15:0];
                next_r.overflow_flag = r.signed_select ? ovf_signed : ovf_unsigned;
                next_r.irq = r.signed_select ? ovf_signed : ovf_unsigned;
                next_r.sign_flag = r.signed_select & sum[31];
                if (!wr_a_high) begin
                    next_r.seq = mdmac_pkg::SEQ_IDLE;
                end else begin
                    next_r.seq = mdmac_pkg::SEQ_PROD;
                end
            end
        endcase

        // Division end: results land and the start bit drops
        if (div_link.done) begin
            next_r.a_high = div_link.quotient[31:16];
            next_r.a_low  = div_link.quotient[15:0];
            next_r.c_high = div_link.remainder[31:16];
            next_r.c_low  = div_link.remainder[15:0];
            next_r.divide_start = 1'b0;
            next_r.irq = ~r.accumulate_select;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Reset clears control to zero: unsigned multiply, flags and start clear
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            r <= '0;
        end else if (CE_I) begin
            r <= next_r;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign ACK_O            = r.ack;
    assign DAT_O            = r.rdata;
    assign ARITH_DONE_IRQ_O = r.irq;

endmodule

// ### verification/mdmac_unit_chk.sv
// Concurrent checks on the ports of the arithmetic unit
`timescale 1ns/1ps
module mdmac_unit_chk (
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_I,
    input  wire logic        CE_I,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    input  wire logic [31:0] DAT_O,
    input  wire logic        ACK_O,
    input  wire logic        ARITH_DONE_IRQ_O
);
    // ----------------------------------------
    // Helper: division cycle counter
    // ----------------------------------------
    logic [4:0] div_cnt;
    logic       div_acc;
    wire  logic ahi_wr = ACK_O && CYC_I && STB_I && WE_I && ADR_I == 8'h04;
    wire  logic go_div = ACK_O && CYC_I && STB_I && WE_I && ADR_I == 8'h00 && SEL_I[0] && DAT_I[7] && DAT_I[0];

    // Counter runs a few cycles past the end so the request window stays visible
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            div_cnt <= 5'h00;
            div_acc <= 1'b0;
        end else if (CE_I) begin
            if (div_cnt == 5'h00 && go_div) begin
                div_cnt <= 5'h01;
                div_acc <= DAT_I[6];
            end else if (div_cnt != 5'h00) begin
                div_cnt <= (div_cnt == 5'h13) ? 5'h00 : div_cnt + 5'h01;
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);

    a_ack_prompt: assert property (CE_I && CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("ack missing one cycle after request");
    a_ack_pulse: assert property (ACK_O && CE_I |=> !ACK_O)
        else $error("ack longer than one cycle");
    a_ack_needs_req: assert property (ACK_O |-> $past(CYC_I && STB_I))
        else $error("ack without request");
    a_read_upper_zero: assert property (ACK_O && !WE_I |-> DAT_O[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_reset_quiet_outputs: assert property ($past(RST_I) |-> !ACK_O && !ARITH_DONE_IRQ_O && DAT_O == 32'h0000_0000)
        else $error("outputs not cleared after reset");
    a_read_data_hold: assert property (!$past(CYC_I && STB_I && !WE_I && !ACK_O) |-> $stable(DAT_O))
        else $error("read data changed without a read");
    a_div_irq_due: assert property (div_cnt == 5'h10 && !div_acc |=> ##[0:1] ARITH_DONE_IRQ_O)
        else $error("division request missing at completion");
    a_div_busy_quiet: assert property (div_cnt != 5'h00 && div_cnt < 5'h10 |-> !ARITH_DONE_IRQ_O)
        else $error("request before division completes");
    a_div_irq_masked: assert property (div_cnt >= 5'h10 && div_acc |-> !ARITH_DONE_IRQ_O)
        else $error("request raised with accumulate select set");
    a_irq_has_cause: assert property (ARITH_DONE_IRQ_O |-> (div_cnt inside {5'h11, 5'h12} && !div_acc)
        || $past(ahi_wr, 3) || $past(ahi_wr, 4))
        else $error("request without a division end or accumulation");

    c_mac_irq: cover property (ahi_wr ##[3:4] ARITH_DONE_IRQ_O);
    c_div_masked: cover property (div_cnt == 5'h10 && div_acc);
    c_read: cover property (ACK_O && !WE_I);
endmodule

bind mdmac_unit mdmac_unit_chk i_mdmac_unit_chk (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .CE_I(CE_I), .CYC_I(CYC_I),
    .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .ARITH_DONE_IRQ_O(ARITH_DONE_IRQ_O));

// ### verification/test_mdmac_unit.sv
// Self-checking bench for the multiply, accumulate and divide unit
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_mdmac_unit;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce  = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we  = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    wire  logic [31:0] dat_o;
    wire  logic        ack;
    wire  logic        irq;
    logic [31:0] q;
    int          fails = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          irqs = 0;

    always #2.5 clk = ~clk;

    mdmac_unit i_mdmac_unit (.REF_CLK_I(clk), .RST_I(rst), .CE_I(ce), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .ARITH_DONE_IRQ_O(irq));

    // ----------------------------------------
    // Bus tasks and run control
    // ----------------------------------------
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Request held until ack is sampled; the next call waits one edge, giving the idle cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        sel <= 4'hF;
        dat <= {16'h0000, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 16'h0000);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        `CHK(q, e)
    endtask

    always @(posedge clk) begin
        if (irq === 1'b1)
            irqs++;
        cycles++;
        if (cycles == 3000) begin
            fails++;
            report_and_stop();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i <= 8'h1C; i += 4) rc(8'(i), 32'h0000_0000);
        wr(8'h1C, 16'hBEEF);
        rc(8'h1C, 32'h0000_0000);
        wr(8'h00, 16'h0007);
        rc(8'h00, 32'h0000_0000);
        $display("test reset_regs done");
        wr(8'h08, 16'h0002);
        wr(8'h04, 16'h0003);
        rc(8'h0C, 32'h0000_0000);
        rc(8'h10, 32'h0000_0006);
        wr(8'h00, 16'h0008);
        wr(8'h04, 16'h7FFF);
        wr(8'h08, 16'hFFFE);
        rc(8'h0C, 32'h0000_FFFF);
        rc(8'h10, 32'h0000_0002);
        $display("test multiply done");
        wr(8'h00, 16'h0040);
        wr(8'h14, 16'h0000);
        wr(8'h18, 16'h0003);
        wr(8'h08, 16'h0002);
        wr(8'h04, 16'h0003);
        rc(8'h10, 32'h0000_0006);
        rc(8'h18, 32'h0000_0009);
        wr(8'h14, 16'hFFFF);
        wr(8'h18, 16'h0002);
        rc(8'h00, 32'h0000_0040);
        wr(8'h08, 16'h7FFF);
        wr(8'h04, 16'h0002);
        rc(8'h10, 32'h0000_FFFE);
        rc(8'h14, 32'h0000_0000);
        rc(8'h18, 32'h0000_0000);
        rc(8'h00, 32'h0000_0044);
        `CHK(irqs, 1)
        $display("test unsigned_mac done");
        wr(8'h00, 16'h0048);
        wr(8'h14, 16'hFFFF);
        rd(8'h00);
        `CHK(q[1], 1'b1)
        wr(8'h18, 16'hFFFC);
        wr(8'h08, 16'h0002);
        wr(8'h04, 16'h0003);
        rc(8'h10, 32'h0000_0006);
        rc(8'h18, 32'h0000_0002);
        rc(8'h00, 32'h0000_0048);
        wr(8'h14, 16'h8000);
        wr(8'h18, 16'h0001);
        wr(8'h08, 16'h7FFF);
        wr(8'h04, 16'hFFFF);
        rc(8'h0C, 32'h0000_FFFF);
        rc(8'h14, 32'h0000_7FFF);
        rc(8'h18, 32'h0000_8002);
        rc(8'h00, 32'h0000_004C);
        `CHK(irqs, 2)
        $display("test signed_mac done");
        for (int k = 0; k < 2; k++) begin
            wr(8'h00, k ? 16'h00C0 : 16'h0080);
            wr(8'h04, 16'h1234);
            wr(8'h08, 16'h5678);
            wr(8'h0C, 16'h0000);
            wr(8'h10, 16'h0100);
            wr(8'h00, k ? 16'h00C1 : 16'h0081);
            // Clock enable low stalls the division; the checker's counter stalls with it
            ce <= 1'b0;
            repeat (8) @(posedge clk);
            ce <= 1'b1;
            wr(8'h00, k ? 16'h00C0 : 16'h0080);
            rd(8'h00);
            // Overflow flag may still hold the last accumulation, so it is masked
            `CHK(q & 32'h0000_00FB, k ? 32'h0000_00C1 : 32'h0000_0081)
            for (int i = 0; i < 20 && q[0] !== 1'b0; i++) rd(8'h00);
            `CHK(q[0], 1'b0)
            repeat (2) @(posedge clk);
            `CHK(irqs, 3)
            rc(8'h04, 32'h0000_0012);
            rc(8'h08, 32'h0000_3456);
            rc(8'h14, 32'h0000_0000);
            rc(8'h18, 32'h0000_0078);
        end
        $display("test divide done");
        report_and_stop();
    end
endmodule
